// ==== hw/ecb_capture_timer.sv ====
// enhanced capture timer: captures, holding registers, accumulators, modulus counter
`timescale 1ns/10ps
`include "ecb_cfg.svh"
module ecb_capture_timer
	import ecb_pkg::*;
#(
	parameter int NUM_CH = `ECB_NUM_CH,
	parameter int NUM_BUF = `ECB_NUM_BUF,
	parameter int CNT_W = `ECB_CNT_W,
	parameter int PACC_W = `ECB_PACC_W,
	parameter int DLY_W = `ECB_DLY_W
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_n_i,
	// timer pins
	input wire logic [NUM_CH-1:0] pin_i,
	// main counter control
	input wire logic timer_enable_i,
	input wire logic [`ECB_MAIN_PRE_W-1:0] main_prescale_i,
	input wire logic cnt_write_i,
	input wire logic [CNT_W-1:0] cnt_wdata_i,
	// configuration
	input wire ecb_pkg::ecb_ch_cfg_t [NUM_CH-1:0] ch_cfg_i,
	input wire ecb_pkg::ecb_sys_cfg_t sys_cfg_i,
	input wire logic [NUM_BUF-1:0][DLY_W-1:0] delay_i,
	// modulus counter control
	input wire logic [`ECB_MOD_PRE_W-1:0] mod_prescale_i,
	input wire logic mod_write_i,
	input wire logic [CNT_W-1:0] mod_wdata_i,
	input wire logic force_latch_bit_i,
	// software read strobes
	input wire logic [NUM_CH-1:0] cap_read_i,
	input wire logic [NUM_BUF-1:0] hold_read_i,
	input wire logic [NUM_BUF-1:0] pacc_hold_read_i,
	// state outputs
	output logic [CNT_W-1:0] main_count_o,
	output logic [CNT_W-1:0] mod_count_o,
	output logic mod_tick_o,
	output logic [NUM_CH-1:0][CNT_W-1:0] capture_o,
	output logic [NUM_BUF-1:0][CNT_W-1:0] holding_o,
	output logic [NUM_CH-1:0] capture_full_o,
	output logic [NUM_BUF-1:0] holding_full_o,
	output logic [NUM_BUF-1:0][PACC_W-1:0] pacc_o,
	output logic [NUM_BUF-1:0][PACC_W-1:0] pacc_hold_o
);
	import ecb_pkg::*;

	logic [`ECB_MAIN_PRE_W-1:0] main_pre_q;
	logic [CNT_W-1:0] main_q;
	logic main_step;
	logic [`ECB_MOD_PRE_W-1:0] mod_pre_q;
	logic [CNT_W-1:0] mod_q;
	logic [CNT_W-1:0] mod_load_q;
	ecb_mod_state_t mod_state_q;
	logic mod_step;
	logic mod_zero;
	logic latch_ev;
	logic [NUM_CH-1:0] cap_ev;
	logic [NUM_CH-1:0][CNT_W-1:0] cap_q;
	logic [NUM_CH-1:0] cap_full_q;
	logic [NUM_BUF-1:0][CNT_W-1:0] hold_q;
	logic [NUM_BUF-1:0] hold_full_q;
	logic [NUM_BUF-1:0][PACC_W-1:0] pacc_q;
	logic [NUM_BUF-1:0][PACC_W-1:0] pacc_hold_q;
	logic [NUM_BUF-1:0] pacc_latch;
	logic [NUM_BUF-1:0] pacc_inc;

	// main timebase with divide by prescale+1
	assign main_step = timer_enable_i && (main_pre_q >= main_prescale_i);
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			main_pre_q <= '0;
		end else if (!timer_enable_i || main_step) begin
			main_pre_q <= '0;
		end else begin
			main_pre_q <= main_pre_q + 1'b1;
		end
	end
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			main_q <= `ECB_CNT_RST;
		end else if (cnt_write_i) begin
			main_q <= cnt_wdata_i;
		end else if (main_step) begin
			main_q <= main_q + 1'b1;
		end
	end
	assign main_count_o = main_q;

	// modulus down counter
	assign mod_step = (mod_state_q == ECB_MOD_RUN) && (mod_pre_q >= mod_prescale_i);
	assign mod_zero = mod_step && (mod_q == 16'h0001);
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			mod_pre_q <= '0;
		end else if (mod_write_i || mod_step || mod_state_q != ECB_MOD_RUN) begin
			mod_pre_q <= '0;
		end else begin
			mod_pre_q <= mod_pre_q + 1'b1;
		end
	end
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			mod_q <= `ECB_CNT_RST;
			mod_load_q <= `ECB_CNT_RST;
			mod_state_q <= ECB_MOD_IDLE;
		end else if (mod_write_i) begin
			mod_q <= mod_wdata_i;
			mod_load_q <= mod_wdata_i;
			mod_state_q <= (mod_wdata_i != 16'h0000 && sys_cfg_i.mod_enable) ?
				ECB_MOD_RUN : ECB_MOD_IDLE;
		end else if (!sys_cfg_i.mod_enable) begin
			mod_state_q <= ECB_MOD_IDLE;
		end else begin
			case (mod_state_q)
				ECB_MOD_IDLE: begin
					if (mod_q != 16'h0000) begin
						mod_state_q <= ECB_MOD_RUN;
					end
				end
				ECB_MOD_RUN: begin
					if (mod_zero) begin
						if (sys_cfg_i.mod_periodic) begin
							mod_q <= mod_load_q;
						end else begin
							mod_q <= '0;
							mod_state_q <= ECB_MOD_DONE;
						end
					end else if (mod_step) begin
						mod_q <= mod_q - 1'b1;
					end
				end
				ECB_MOD_DONE: mod_state_q <= ECB_MOD_DONE;
				default: mod_state_q <= ECB_MOD_IDLE;
			endcase
		end
	end
	assign mod_count_o = mod_q;
	assign mod_tick_o = mod_zero;

	// latch event sources, latch mode only
	assign latch_ev = (sys_cfg_i.latch_queue_select == `ECB_LATCH_QUEUE_SELECT_LATCH) &&
		(mod_zero || (mod_write_i && mod_wdata_i == 16'h0000) || force_latch_bit_i);

	// filtered edge detection per channel
	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++) begin : g_ch
			logic [DLY_W-1:0] dly;
			logic ev;
			if (g >= NUM_CH - NUM_BUF) begin : g_dly
				assign dly = delay_i[g-(NUM_CH-NUM_BUF)];
			end else begin : g_nodly
				assign dly = '0;
			end
			ecb_edge_filter #(
				.DLY_W(DLY_W)
			) u_filt (
				.clk_i(clk_i),
				.reset_n_i(reset_n_i),
				.delay_i(dly),
				.edge_sel_i(ch_cfg_i[g].edge_sel),
				.pin_i(pin_i[g]),
				.event_o(ev)
			);
			assign cap_ev[g] = ev && (ch_cfg_i[g].channel_function_select_bit ==
				`ECB_SEL_CAPTURE);

			if (g < NUM_CH - NUM_BUF) begin : g_plain
				always_ff @(posedge clk_i or negedge reset_n_i) begin
					if (!reset_n_i) begin
						cap_q[g] <= `ECB_CNT_RST;
						cap_full_q[g] <= 1'b0;
					end else if (cap_ev[g] && (!ch_cfg_i[g].no_overwrite_bit ||
						!cap_full_q[g])) begin
						cap_q[g] <= main_q;
						cap_full_q[g] <= 1'b1;
					end else if (cap_read_i[g]) begin
						cap_full_q[g] <= 1'b0;
					end
				end
			end else begin : g_buf
				localparam int B = g - (NUM_CH - NUM_BUF);
				logic nov;
				logic latchm;
				logic do_cap;
				logic do_move;
				assign nov = ch_cfg_i[g].no_overwrite_bit;
				assign latchm = (sys_cfg_i.latch_queue_select == `ECB_LATCH_QUEUE_SELECT_LATCH);
				// latch: capture->holding on latch event; queue: shift on capture
				always_comb begin
					if (latchm) begin
						do_move = latch_ev && (!nov || !hold_full_q[B]);
						do_cap = cap_ev[g] && (!nov || !cap_full_q[g] || do_move);
					end else begin
						do_move = cap_ev[g] && cap_full_q[g] &&
							(!nov || !hold_full_q[B]);
						do_cap = cap_ev[g] && (!nov || !cap_full_q[g] || do_move);
					end
				end
				always_ff @(posedge clk_i or negedge reset_n_i) begin
					if (!reset_n_i) begin
						cap_q[g] <= `ECB_CNT_RST;
						cap_full_q[g] <= 1'b0;
					end else if (do_cap) begin
						cap_q[g] <= main_q;
						cap_full_q[g] <= 1'b1;
					end else if (do_move || cap_read_i[g]) begin
						cap_full_q[g] <= 1'b0;
					end
				end
				always_ff @(posedge clk_i or negedge reset_n_i) begin
					if (!reset_n_i) begin
						hold_q[B] <= `ECB_CNT_RST;
						hold_full_q[B] <= 1'b0;
					end else if (do_move) begin
						hold_q[B] <= cap_q[g];
						hold_full_q[B] <= cap_full_q[g] || hold_full_q[B];
					end else if (hold_read_i[B]) begin
						hold_full_q[B] <= 1'b0;
					end
				end
				assign pacc_inc[B] = cap_ev[g];
				assign pacc_latch[B] = latchm ? latch_ev : hold_read_i[B];
			end
		end
	endgenerate

	// accumulators; odd index carries from even when paired
	generate
		for (g = 0; g < NUM_BUF; g++) begin : g_pacc
			logic carry_in;
			logic paired;
			logic [PACC_W-1:0] nxt;
			if (g % 2 == 1) begin : g_hi
				assign paired = (g == 1) ? sys_cfg_i.pair_lo : sys_cfg_i.pair_hi;
				assign carry_in = paired ? (pacc_inc[g-1] && pacc_q[g-1] == `ECB_PACC_MAX) :
					pacc_inc[g];
			end else begin : g_lo
				assign paired = (g == 0) ? sys_cfg_i.pair_lo : sys_cfg_i.pair_hi;
				assign carry_in = pacc_inc[g];
			end
			always_comb begin
				nxt = pacc_q[g];
				if (carry_in) begin
					if (sys_cfg_i.accumulator_saturate_bit && !paired &&
						pacc_q[g] == `ECB_PACC_MAX) begin
						nxt = pacc_q[g];
					end else begin
						nxt = pacc_q[g] + 1'b1;
					end
				end
			end
			always_ff @(posedge clk_i or negedge reset_n_i) begin
				if (!reset_n_i) begin
					pacc_q[g] <= `ECB_PACC_RST;
					pacc_hold_q[g] <= `ECB_PACC_RST;
				end else if (pacc_latch[g]) begin
					pacc_hold_q[g] <= pacc_q[g];
					pacc_q[g] <= `ECB_PACC_RST;
				end else begin
					pacc_q[g] <= nxt;
				end
			end
		end
	endgenerate

	// register values exposed as whole words
	assign capture_o = cap_q;
	assign holding_o = hold_q;
	assign capture_full_o = cap_full_q;
	assign holding_full_o = hold_full_q;
	assign pacc_o = pacc_q;
	assign pacc_hold_o = pacc_hold_q;
endmodule

// ==== hw/ecb_cfg.svh ====
// constants of the capture block: widths, reset values, edge codes
`ifndef ECB_CFG_SVH
`define ECB_CFG_SVH
`define ECB_NUM_CH 8
`define ECB_NUM_BUF 4
`define ECB_CNT_W 16
`define ECB_PACC_W 8
`define ECB_MAIN_PRE_W 7
`define ECB_MOD_PRE_W 4
`define ECB_DLY_W 8
`define ECB_CNT_RST 16'h0000
`define ECB_PACC_RST 8'h00
`define ECB_PACC_MAX 8'hFF
`define ECB_EDGE_OFF 2'h0
`define ECB_EDGE_RISE 2'h1
`define ECB_EDGE_FALL 2'h2
`define ECB_EDGE_ANY 2'h3
`define ECB_SEL_CAPTURE 1'b0
`define ECB_LATCH_QUEUE_SELECT_LATCH 1'b1
`endif

// ==== hw/ecb_pkg.sv ====
// types of the capture block
package ecb_pkg;
	typedef struct packed {
		logic [1:0] edge_sel;
		logic no_overwrite_bit;
		logic channel_function_select_bit;
	} ecb_ch_cfg_t;
	typedef struct packed {
		logic latch_queue_select;
		logic accumulator_saturate_bit;
		logic pair_lo;
		logic pair_hi;
		logic mod_enable;
		logic mod_periodic;
	} ecb_sys_cfg_t;
	typedef enum logic [1:0] {
		ECB_MOD_IDLE,
		ECB_MOD_RUN,
		ECB_MOD_DONE
	} ecb_mod_state_t;
endpackage

// ==== hw/ecb_edge_filter.sv ====
// per-input delay filter and edge detector
`timescale 1ns/10ps
`include "ecb_cfg.svh"
module ecb_edge_filter #(
	parameter int DLY_W = `ECB_DLY_W
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_n_i,
	// configuration
	input wire logic [DLY_W-1:0] delay_i,
	input wire logic [1:0] edge_sel_i,
	// pin and event
	input wire logic pin_i,
	output logic event_o
);
	logic stable_q;
	logic cand_q;
	logic [DLY_W-1:0] cnt_q;
	logic accept;
	logic rise;
	logic fall;

	// level must hold delay_i cycles before accepted
	assign accept = (pin_i == cand_q) && (cnt_q >= delay_i) && (cand_q != stable_q);
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cand_q <= 1'b0;
			cnt_q <= '0;
		end else if (pin_i != cand_q) begin
			cand_q <= pin_i;
			cnt_q <= '0;
		end else if (cnt_q != {DLY_W{1'b1}}) begin
			cnt_q <= cnt_q + 1'b1;
		end
	end
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			stable_q <= 1'b0;
		end else if (accept) begin
			stable_q <= cand_q;
		end
	end
	assign rise = accept && cand_q;
	assign fall = accept && !cand_q;
	always_comb begin
		case (edge_sel_i)
			`ECB_EDGE_RISE: event_o = rise;
			`ECB_EDGE_FALL: event_o = fall;
			`ECB_EDGE_ANY: event_o = rise || fall;
			default: event_o = 1'b0;
		endcase
	end
endmodule

// ==== verification/ecb_pin_model.sv ====
// timer input pin model: drives the capture pins from bench levels
`timescale 1ns/10ps
module ecb_pin_model (
	// clock
	input wire logic clk_i,
	// requested levels and pins
	input wire logic [7:0] level_i,
	output logic [7:0] pin_o
);
	initial pin_o = 8'h00;
	// each pin takes its requested level one clock later, registered on the rising edge
	always @(posedge clk_i) begin
		pin_o <= level_i;
	end
endmodule

// ==== verification/ecb_capture_timer_assertions.sv ====
// concurrent checks on the capture timer ports
`timescale 1ns/10ps
module ecb_capture_timer_assertions
	import ecb_pkg::*;
#(
	parameter int NUM_CH = 8,
	parameter int NUM_BUF = 4,
	parameter int CNT_W = 16,
	parameter int PACC_W = 8
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_n_i,
	// watched inputs
	input wire logic timer_enable_i,
	input wire logic [6:0] main_prescale_i,
	input wire logic cnt_write_i,
	input wire ecb_pkg::ecb_ch_cfg_t [NUM_CH-1:0] ch_cfg_i,
	input wire ecb_pkg::ecb_sys_cfg_t sys_cfg_i,
	input wire logic mod_write_i,
	input wire logic [CNT_W-1:0] mod_wdata_i,
	input wire logic force_latch_bit_i,
	input wire logic [NUM_CH-1:0] cap_read_i,
	input wire logic [NUM_BUF-1:0] hold_read_i,
	// watched outputs
	input wire logic [CNT_W-1:0] main_count_o,
	input wire logic mod_tick_o,
	input wire logic [NUM_CH-1:0][CNT_W-1:0] capture_o,
	input wire logic [NUM_BUF-1:0][CNT_W-1:0] holding_o,
	input wire logic [NUM_CH-1:0] capture_full_o,
	input wire logic [NUM_BUF-1:0][PACC_W-1:0] pacc_o,
	input wire logic [NUM_BUF-1:0][PACC_W-1:0] pacc_hold_o
);
	logic lt;
	logic ev;
	assign lt = sys_cfg_i.latch_queue_select;
	assign ev = force_latch_bit_i || (mod_write_i && mod_wdata_i == 16'h0000) || mod_tick_o;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	a_main_count_step: assert property (timer_enable_i && $past(timer_enable_i, 2)
		&& $past(timer_enable_i) && main_prescale_i == 7'h00 && $past(main_prescale_i) == 7'h00
		&& !$past(cnt_write_i) |-> main_count_o == $past(main_count_o) + 16'h0001)
		else $error("main counter did not step");
	a_read_empties: assert property (cap_read_i[0] && ch_cfg_i[0].edge_sel == 2'h0
		&& $past(ch_cfg_i[0].edge_sel) == 2'h0 |=> !capture_full_o[0])
		else $error("read left capture full");
	a_protect_capture: assert property (ch_cfg_i[0].no_overwrite_bit && capture_full_o[0]
		&& !cap_read_i[0] |=> capture_o[0] == $past(capture_o[0]))
		else $error("protected capture overwritten");
	a_latch_moves: assert property (lt && ev && !ch_cfg_i[4].no_overwrite_bit
		&& !sys_cfg_i.pair_lo |=> holding_o[0] == $past(capture_o[4])
		&& pacc_hold_o[0] == $past(pacc_o[0]))
		else $error("latch event did not move values");
	a_pacc_saturates: assert property (sys_cfg_i.accumulator_saturate_bit
		&& !sys_cfg_i.pair_hi && pacc_o[2] == 8'hFF && !ev && !hold_read_i[2]
		|=> pacc_o[2] == 8'hFF)
		else $error("saturated accumulator wrapped");
	a_queue_shift: assert property (!lt && !ch_cfg_i[5].no_overwrite_bit
		&& capture_full_o[5] && !cap_read_i[5] ##1 capture_o[5] != $past(capture_o[5])
		|-> holding_o[1] == $past(capture_o[5]))
		else $error("queue did not shift old capture");
	a_hold_read_pacc: assert property (!lt && hold_read_i[1] && !sys_cfg_i.pair_lo
		|=> pacc_hold_o[1] == $past(pacc_o[1]))
		else $error("holding read did not copy accumulator");
	a_compare_no_capture: assert property (ch_cfg_i[1].channel_function_select_bit
		|=> capture_o[1] == $past(capture_o[1]))
		else $error("compare channel captured");
	c_latch: cover property (lt && ev);
	c_tick: cover property (mod_tick_o);
	c_sat: cover property (pacc_o[2] == 8'hFF);
endmodule
bind ecb_capture_timer ecb_capture_timer_assertions #(.NUM_CH(NUM_CH), .NUM_BUF(NUM_BUF),
	.CNT_W(CNT_W), .PACC_W(PACC_W)) u_chk (.clk_i, .reset_n_i, .timer_enable_i,
	.main_prescale_i, .cnt_write_i, .ch_cfg_i, .sys_cfg_i, .mod_write_i, .mod_wdata_i,
	.force_latch_bit_i, .cap_read_i, .hold_read_i, .main_count_o, .mod_tick_o, .capture_o,
	.holding_o, .capture_full_o, .pacc_o, .pacc_hold_o);

// ==== verification/ecb_capture_timer_test.sv ====
// self-checking bench of the capture timer
`timescale 1ns/10ps
module ecb_capture_timer_test;
	import ecb_pkg::*;
	logic clk_i = 0, reset_n_i = 0, en = 0, cw = 0, mw = 0, fl = 0, tick;
	logic [15:0] cwd = 16'h0000, mwd = 16'h0000, mcnt, mcount;
	logic [7:0] pr = 8'h00, crd = 8'h00, pins, cfull;
	logic [3:0] hrd = 4'h0, hfull;
	ecb_ch_cfg_t [7:0] cfg = '0;
	ecb_sys_cfg_t sys = '0;
	logic [7:0][15:0] cap;
	logic [3:0][15:0] hold;
	logic [3:0][7:0] pacc, ph;
	int mismatches = 0, n_compared = 0, n;
	logic [6:0] mps = 7'h00;
	logic [3:0] dps = 4'h0;
	logic [3:0][7:0] dly = '0;
	logic [15:0] m0;
	always #5 clk_i = ~clk_i;
	ecb_pin_model u_pins (.clk_i(clk_i), .level_i(pr), .pin_o(pins));
	ecb_capture_timer DUT (.clk_i(clk_i), .reset_n_i(reset_n_i), .pin_i(pins),
		.timer_enable_i(en), .main_prescale_i(mps), .cnt_write_i(cw), .cnt_wdata_i(cwd),
		.ch_cfg_i(cfg), .sys_cfg_i(sys), .delay_i(dly), .mod_prescale_i(dps),
		.mod_write_i(mw), .mod_wdata_i(mwd), .force_latch_bit_i(fl), .cap_read_i(crd),
		.hold_read_i(hrd), .pacc_hold_read_i(4'h0), .main_count_o(mcnt), .mod_count_o(mcount),
		.mod_tick_o(tick), .capture_o(cap), .holding_o(hold), .capture_full_o(cfull),
		.holding_full_o(hfull), .pacc_o(pacc), .pacc_hold_o(ph));
	task wt(input int k); repeat (k) @(posedge clk_i); @(negedge clk_i); endtask
	task tog(input logic [7:0] m); @(posedge clk_i); pr <= pr ^ m; wt(5); endtask
	task ld(input logic [15:0] v);
		@(posedge clk_i); cw <= 1'b1; cwd <= v; @(posedge clk_i); cw <= 1'b0; wt(1);
	endtask
	task mwr(input logic [15:0] v);
		@(posedge clk_i); mw <= 1'b1; mwd <= v; @(posedge clk_i); mw <= 1'b0; wt(1);
	endtask
	task rd(input logic [7:0] m); @(posedge clk_i); crd <= m; @(posedge clk_i); crd <= 8'h00; wt(1); endtask
	task hr(input logic [3:0] m); @(posedge clk_i); hrd <= m; @(posedge clk_i); hrd <= 4'h0; wt(1); endtask
	task flt; @(posedge clk_i); fl <= 1'b1; @(posedge clk_i); fl <= 1'b0; wt(1); endtask
	task chk(input logic [15:0] g, input logic [15:0] e);
		n_compared++;
		if (g !== e) begin
			mismatches++;
			$display("ERROR %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task t_edges;
		logic [1:0] c;
		for (int i = 0; i < 4; i++) begin
			c = i[1:0];
			@(posedge clk_i); cfg[0].edge_sel <= c;
			ld({14'h0440, c}); rd(8'h01); tog(8'h03);
			chk({15'h0, cfull[0]}, {15'h0, c[0]});
			if (c[0]) chk(cap[0], {14'h0440, c});
			rd(8'h01); chk({15'h0, cfull[0]}, 16'h0000);
			ld({14'h0880, c}); tog(8'h03);
			chk({15'h0, cfull[0]}, {15'h0, c[1]});
			if (c[1]) chk(cap[0], {14'h0880, c});
		end
	endtask
	task t_protect;
		@(posedge clk_i); cfg[0].edge_sel <= 2'h3; cfg[0].no_overwrite_bit <= 1'b1;
		rd(8'h01); ld(16'hA001); tog(8'h01); ld(16'hA002); tog(8'h01);
		chk(cap[0], 16'hA001);
		@(posedge clk_i); cfg[0].no_overwrite_bit <= 1'b0;
		tog(8'h01); chk(cap[0], 16'hA002);
	endtask
	task t_latch;
		@(posedge clk_i); sys.latch_queue_select <= 1'b1; cfg[4].edge_sel <= 2'h3;
		ld(16'h4444); flt; repeat (3) tog(8'h10);
		flt; chk(hold[0], 16'h4444);
		chk({8'h00, ph[0]}, 16'h0003); chk({8'h00, pacc[0]}, 16'h0000);
		ld(16'h5555); tog(8'h10); mwr(16'h0000);
		chk(hold[0], 16'h5555); chk({8'h00, ph[0]}, 16'h0001);
		@(posedge clk_i); cfg[4].no_overwrite_bit <= 1'b1;
		ld(16'h6666); tog(8'h10); flt; chk(hold[0], 16'h5555);
		chk({15'h0, hfull[0]}, 16'h0001);
	endtask
	task t_queue;
		@(posedge clk_i); sys.latch_queue_select <= 1'b0; cfg[5].edge_sel <= 2'h3;
		rd(8'h20); hr(4'h2); ld(16'h7777); tog(8'h20); ld(16'h8888); tog(8'h20);
		chk(hold[1], 16'h7777); chk(cap[5], 16'h8888);
		hr(4'h2); chk({8'h00, ph[1]}, 16'h0002); chk({8'h00, pacc[1]}, 16'h0000);
		chk({15'h0, hfull[1]}, 16'h0000);
		ld(16'h9999); tog(8'h20);
		@(posedge clk_i); cfg[5].no_overwrite_bit <= 1'b1;
		ld(16'hAAAA); tog(8'h20); chk(cap[5], 16'h9999); chk(hold[1], 16'h8888);
	endtask
	task t_accum;
		@(posedge clk_i); sys.accumulator_saturate_bit <= 1'b1; cfg[6].edge_sel <= 2'h3;
		hr(4'hC); repeat (260) tog(8'h40); chk({8'h00, pacc[2]}, 16'h00FF);
		hr(4'hC);
		@(posedge clk_i); sys.accumulator_saturate_bit <= 1'b0; sys.pair_hi <= 1'b1;
		repeat (260) tog(8'h40); chk({pacc[3], pacc[2]}, 16'h0104);
	endtask
	task ticks(input logic per, output int k);
		@(posedge clk_i); sys.mod_periodic <= per; mwr(16'h0003); k = 0;
		repeat (40) begin @(negedge clk_i); k += tick; end
	endtask
	task t_modulus;
		@(posedge clk_i); sys.latch_queue_select <= 1'b1; sys.mod_enable <= 1'b1; en <= 1'b1;
		ticks(1'b1, n); chk({15'h0, n >= 12}, 16'h0001);
		ticks(1'b0, n); chk(n[15:0], 16'h0001);
		chk(mcount, 16'h0000);
		@(posedge clk_i); dps <= 4'h1;
		ticks(1'b1, n); chk({15'h0, n >= 6 && n <= 8}, 16'h0001);
		@(posedge clk_i); mps <= 7'h03;
		wt(2);
		m0 = mcnt;
		wt(40);
		chk(mcnt - m0, 16'h000A);
		@(posedge clk_i); en <= 1'b0;
	endtask
	task t_delay;
		@(posedge clk_i); sys.latch_queue_select <= 1'b0; sys.mod_enable <= 1'b0;
		cfg[7].edge_sel <= 2'h3;
		dly[3] <= 8'h06;
		rd(8'h80);
		@(posedge clk_i); pr <= pr ^ 8'h80;
		wt(2);
		@(posedge clk_i); pr <= pr ^ 8'h80;
		wt(12);
		chk({15'h0, cfull[7]}, 16'h0000);
		@(posedge clk_i); pr <= pr ^ 8'h80;
		wt(12);
		chk({15'h0, cfull[7]}, 16'h0001);
	endtask
	task wrap_up;
		$display("mismatches %0d compared %0d", mismatches, n_compared);
		if (mismatches == 0 && n_compared > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	initial begin
		cfg[1].channel_function_select_bit <= 1'b1;
		cfg[1].edge_sel <= 2'h3;
		repeat (10) @(posedge clk_i);
		reset_n_i <= 1'b1;
		t_edges; t_protect; t_latch; t_queue; t_accum; t_modulus; t_delay;
		wrap_up;
	end
	initial begin #300000; mismatches++; wrap_up; end
endmodule
